/* File: inc/comb_pkg.sv */
`default_nettype none
package comb_pkg;
   // composite sample width from the flash converter
   localparam int SAMPLE_W       = 8;
   // samples per line at four times subcarrier: 455/2 * 4 = 910
   localparam int LINE_SAMPLES   = 910;
   // subcarrier quarter-period phase count
   localparam int PHASE_W        = 2;
   localparam logic [1:0] PHASE_RESET = 2'h0;
   // subcarrier and sample rate figures
   localparam real SUBCARRIER_MHZ = 3.579545;
   localparam real SAMPLE_MHZ     = 4.0 * SUBCARRIER_MHZ;
   // reset value of stored words
   localparam logic [SAMPLE_W-1:0] SAMPLE_ZERO = 8'h00;
   // sequence value selections
   typedef enum logic [1:0] {seq_zero_type_v, seq_pos, seq_neg} seq_type;
endpackage
`default_nettype wire

/* File: inc/word_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface word_if #(parameter int W = 8);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: logic/skid_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
module skid_buffer #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic srst,
   // filling and draining sides
   word_if.dst       in_side,
   word_if.src       out_side
);
   if (W < 1) begin : g_param_check
      $error("skid_buffer: bad width");
   end

   logic [W-1:0] slot_reg [2];
   logic         rd_ptr_reg;
   logic         wr_ptr_reg;
   logic [1:0]   count_reg;
   wire          push = in_side.valid & in_side.ready;
   wire          pop  = out_side.valid & out_side.ready;

   assign in_side.ready  = (count_reg != 2'h2);
   assign out_side.valid = (count_reg != 2'h0);
   assign out_side.data  = slot_reg[rd_ptr_reg];

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rd_ptr_reg <= 1'b0;
         wr_ptr_reg <= 1'b0;
         count_reg  <= 2'h0;
      end else begin
         if (push) wr_ptr_reg <= ~wr_ptr_reg;
         if (pop) rd_ptr_reg <= ~rd_ptr_reg;
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) slot_reg[wr_ptr_reg] <= in_side.data;
   end
endmodule
`default_nettype wire

/* File: logic/comb_demod.sv */
// Notes on behaviour
// R1: luma is current plus previous-line sample
// R2: chroma is current minus previous-line sample
// R3: one-line delay from FIFO line memory
// R4: relies on carrier inverting between lines
// R5: sample clock is four times subcarrier
// R6: red from sine, blue from cosine
// R7: sequence 1 passes, 0 gives zero
// R8: sequence -1 gives two's complement negation
// R9: sine 0,1,0,-1; cosine 1,0,-1,0
`timescale 1ns/1ps
`default_nettype none
module comb_demod #(
   parameter int SW    = comb_pkg::SAMPLE_W,
   parameter int LINE  = comb_pkg::LINE_SAMPLES
) (
   // clock and reset
   input  wire logic          sys_clk,
   input  wire logic          srst,
   // composite input stream
   input  wire logic          in_valid,
   input  wire logic [SW-1:0] in_sample,
   output var  logic          in_ready,
   // separated outputs, one word per accepted sample
   output var  logic          out_valid,
   input  wire logic          out_ready,
   output var  logic [SW:0]   luma_x2,
   output var  logic [SW:0]   chroma_x2,
   output var  logic [SW+1:0] red_diff,
   output var  logic [SW+1:0] blue_diff
);
   import comb_pkg::*;

   // narrower words or a one-sample line leave no room for the sign
   if (SW < 2 || LINE < 2) begin : g_param_check
      $error("comb_demod: bad parameters");
   end

   localparam int PW  = 4 * SW + 6;
   localparam int AW  = $clog2(LINE);
   localparam logic [AW-1:0] LAST = AW'(LINE - 1);

   ////////////////////////////////////////////////////////////////////////
   // line memory: read and write the same slot, so it acts as a fifo
   // of exactly one line length
   logic [SW-1:0] line_mem [LINE];
   logic [AW-1:0] addr_reg;
   logic [1:0]    phase_reg;
   logic          in_ready_reg;

   word_if #(.W(PW)) fill ();
   word_if #(.W(PW)) drain ();

   wire           take     = in_valid & in_ready_reg;
   wire [SW-1:0]  prev_s   = line_mem[addr_reg];                 // [R3]
   // offset-binary samples: unsigned sum and signed difference keep one extra bit
   wire [SW:0]    sum_w    = {1'b0, in_sample} + {1'b0, prev_s}; // [R1]
   wire [SW:0]    diff_w   = {1'b0, in_sample} - {1'b0, prev_s}; // [R2] [R4]

   ////////////////////////////////////////////////////////////////////////
   // sequence selection, one quarter carrier period per sample
   seq_type sin_sel;
   seq_type cos_sel;
   assign sin_sel = (phase_reg == 2'h1) ? seq_pos :
                    (phase_reg == 2'h3) ? seq_neg : seq_zero_type_v; // [R9]
   assign cos_sel = (phase_reg == 2'h0) ? seq_pos :
                    (phase_reg == 2'h2) ? seq_neg : seq_zero_type_v; // [R9]

   wire [SW+1:0] chroma_ext = {diff_w[SW], diff_w};

   function automatic logic [SW+1:0] apply_seq(input seq_type s,
                                                input logic [SW+1:0] c);
      logic [SW+1:0] r;
      r = '0;
      case (s)
         seq_pos: r = c;                                        // [R7]
         seq_neg: r = (~c) + 1'b1;                              // [R8]
         seq_zero_type_v: r = '0;                               // [R7]
         default: r = '0;
      endcase
      return r;
   endfunction

   wire [SW+1:0] red_w  = apply_seq(sin_sel, chroma_ext);       // [R6]
   wire [SW+1:0] blue_w = apply_seq(cos_sel, chroma_ext);       // [R6]

   assign fill.valid = take;
   assign fill.data  = {sum_w, diff_w, red_w, blue_w};

   ////////////////////////////////////////////////////////////////////////
   // stall when the buffer cannot take another word, so no word is lost
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         addr_reg     <= '0;
         phase_reg    <= PHASE_RESET;
         in_ready_reg <= 1'b0;
      end else begin
         in_ready_reg <= fill.ready & ~(take & in_ready_reg & ~drain.ready);
         if (take) begin
            addr_reg  <= (addr_reg == LAST) ? '0 : addr_reg + 1'b1;
            phase_reg <= phase_reg + 2'h1;                      // [R5]
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (take) line_mem[addr_reg] <= in_sample;                // [R3]
   end

   assign in_ready = in_ready_reg;

   skid_buffer #(.W(PW)) buf_i (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .in_side  (fill),
      .out_side (drain)
   );

   ////////////////////////////////////////////////////////////////////////
   // output register stage
   logic out_valid_reg;
   assign drain.ready = ~out_valid_reg | out_ready;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         out_valid_reg <= 1'b0;
         luma_x2       <= '0;
         chroma_x2     <= '0;
         red_diff      <= '0;
         blue_diff     <= '0;
      end else if (drain.ready) begin
         out_valid_reg <= drain.valid;
         if (drain.valid) begin
            {luma_x2, chroma_x2, red_diff, blue_diff} <= drain.data;
         end
      end
   end

   assign out_valid = out_valid_reg;
endmodule
`default_nettype wire

/* File: testbench/comb_demod_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module comb_demod_properties #(
   parameter int SW = 8,
   parameter int LINE = 910
) (
   input wire logic          sys_clk,
   input wire logic          srst,
   input wire logic          out_valid,
   input wire logic          out_ready,
   input wire logic [SW:0]   luma_x2,
   input wire logic [SW:0]   chroma_x2,
   input wire logic [SW+1:0] red_diff,
   input wire logic [SW+1:0] blue_diff
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic [1:0]   ph_reg;
   logic [15:0]  n_reg;
   wire          go = out_valid && out_ready;
   // first line meets unwritten memory, so data checks wait a line
   wire          warm = go && n_reg >= 16'(LINE);
   wire [SW+1:0] c = {chroma_x2[SW], chroma_x2};
   // twice the current and twice the previous sample, never negative
   wire [SW+1:0] cur2  = {1'b0, luma_x2} + c;
   wire [SW+1:0] prev2 = {1'b0, luma_x2} - c;
   always_ff @(posedge sys_clk) begin
      ph_reg <= srst ? 2'h0 : ph_reg + 2'(go);
      n_reg <= srst ? 16'h0 : n_reg + 16'(go && n_reg < 16'(LINE));
   end
   sequence stalled;
      out_valid && !out_ready;
   endsequence
   // first-line words carry unwritten memory, so data holds wait a line
   sequence stalled_settled;
      stalled ##0 n_reg >= 16'(LINE);
   endsequence
   a_seq_cos: assert property (warm && ph_reg == 0 |->
      red_diff == 0 && blue_diff == c) else $error("phase 0");
   a_seq_pass: assert property (warm && ph_reg == 1 |->
      red_diff == c && blue_diff == 0) else $error("phase 1");
   a_seq_neg: assert property (warm && ph_reg == 2 |->
      red_diff == 0 && blue_diff == -c) else $error("phase 2");
   a_sine_neg: assert property (warm && ph_reg == 3 |->
      red_diff == -c && blue_diff == 0) else $error("phase 3");
   a_sum_parity: assert property (warm |->
      luma_x2[0] == chroma_x2[0]) else $error("parity");
   a_diff_range: assert property (warm |->
      !cur2[SW+1] && !prev2[SW+1] && !cur2[0]) else $error("range");
   a_hold_stall: assert property (stalled |=> out_valid)
      else $error("hold");
   a_hold_data: assert property (stalled_settled |=>
      $stable(luma_x2) && $stable(chroma_x2) && $stable(red_diff) &&
      $stable(blue_diff)) else $error("hold data");
   a_reset_idle: assert property ($fell(srst) |-> !out_valid)
      else $error("reset");
endmodule
bind comb_demod comb_demod_properties #(.SW(SW), .LINE(LINE)) u_props (
   .sys_clk, .srst, .out_valid, .out_ready, .luma_x2, .chroma_x2,
   .red_diff, .blue_diff);
`default_nettype wire

/* File: testbench/video_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module video_sink (
   input  wire logic stall,
   output wire logic out_ready
);
   // takes a word every cycle it is not stalled
   assign out_ready = !stall;
endmodule
`default_nettype wire

/* File: testbench/comb_demod_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module comb_demod_tb;
   localparam int L = 8;
   logic sys_clk = 0, srst = 1, in_valid = 0, stall = 0;
   logic [7:0] in_sample = 8'h00;
   wire logic in_ready, out_valid, out_ready;
   wire logic [8:0] luma_x2, chroma_x2;
   wire logic [9:0] red_diff, blue_diff;
   logic [37:0] q[$];
   int failures = 0, n_tests = 0;
   comb_demod #(.LINE(L)) u_comb_demod (.sys_clk, .srst, .in_valid,
      .in_sample, .in_ready, .out_valid, .out_ready, .luma_x2,
      .chroma_x2, .red_diff, .blue_diff);
   video_sink u_video_sink (.stall, .out_ready);
   initial forever #10 sys_clk = ~sys_clk;
   // five-cycle stalls fill the buffer so the input is refused
   always @(posedge sys_clk) #1 stall = $time / 20 % 16 > 10;
   // a word seen here is taken at the next rising edge
   always @(negedge sys_clk) if (out_valid && out_ready) begin
      q.push_back({luma_x2, chroma_x2, red_diff, blue_diff});
   end
   function automatic logic [7:0] val(int n);
      return n % 7 == 3 ? 8'hFF : 8'(n * n * 13);
   endfunction
   task automatic chk(logic [37:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("failures %0d n_tests %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic stream_lines();
      int k;
      in_valid = 1;
      for (int n = 0; n < 3 * L; n++) begin
         in_sample = val(n);
         // in_ready is registered: its level now holds to the next edge
         for (k = 0; k < 40 && in_ready !== 1'b1; k++) begin
            @(posedge sys_clk);
            #1;
         end
         if (k == 40) begin failures++; results(); end
         @(posedge sys_clk);
         #1;
      end
      in_valid = 0;
   endtask
   // one extra sample leaves phase and line address off zero, so the
   // next pass shows that reset restarts the phase; the checks skip the first line, so the address restart is not seen
   task automatic reset_mid();
      int k;
      @(posedge sys_clk);
      #1;
      in_valid = 1;
      in_sample = 8'h5A;
      for (k = 0; k < 40 && in_ready !== 1'b1; k++) begin
         @(posedge sys_clk);
         #1;
      end
      if (k == 40) begin failures++; results(); end
      @(posedge sys_clk);
      #1;
      in_valid = 0;
      srst = 1;
      repeat (2) @(posedge sys_clk);
      #1;
      chk({luma_x2, chroma_x2, red_diff, blue_diff}, 38'h0);
      chk({36'h0, out_valid, in_ready}, 38'h0);
      srst = 0;
      q.delete();
   endtask
   task automatic check_demod();
      logic [9:0] c, r, b;
      logic [8:0] l;
      int k;
      for (k = 0; k < 200 && q.size() < 3 * L; k++) @(posedge sys_clk);
      if (k == 200) begin failures++; results(); end
      for (int n = L; n < 3 * L; n++) begin
         l = {1'b0, val(n)} + {1'b0, val(n - L)};
         c = {2'b00, val(n)} - {2'b00, val(n - L)};
         r = n % 4 == 1 ? c : n % 4 == 3 ? -c : 10'h000;
         b = n % 4 == 0 ? c : n % 4 == 2 ? -c : 10'h000;
         chk(q[n], {l, c[8:0], r, b});
      end
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      #1 srst = 0;
      stream_lines();
      check_demod();
      reset_mid();
      stream_lines();
      check_demod();
      results();
   end
endmodule
`default_nettype wire
